//--- core/rcw_pkg.sv
// constants for the receiver configuration word decoder
// assumes one 50 MHz clock domain and a host that shifts words bit 1 first
package rcw_pkg;
  // ==========================================
  // word layout
  localparam int unsigned WORD_LEN     = 15;
  localparam int unsigned PAYLOAD_LEN  = 12;
  localparam logic [3:0]  BIT_CNT_LAST = 4'hE;
  // ==========================================
  // reset values, payload bit 3 in the msb
  localparam logic [11:0] OPCFG_RST    = 12'h189;
  localparam logic [11:0] LIMITS_RST   = 12'h569;
  // ==========================================
  // operating register field positions
  localparam int unsigned OP_BAUD_HI   = 11;
  localparam int unsigned OP_BAUD_LO   = 10;
  localparam int unsigned OP_CHK_HI    = 9;
  localparam int unsigned OP_CHK_LO    = 8;
  localparam int unsigned OP_MOD       = 7;
  localparam int unsigned OP_SLP_MSB   = 6;
  localparam int unsigned OP_SLP_LSB   = 2;
  localparam int unsigned OP_SLP_EXT   = 1;
  localparam int unsigned OP_NOISE     = 0;
  localparam logic [4:0]  SLEEP_PERM   = 5'h1F;
  // ==========================================
  // marker pattern shifted out after supply loss
  localparam logic [7:0]  MARKER_PAT   = 8'hA5;
  localparam logic [2:0]  MARKER_LAST  = 3'h7;
  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_SHIFT= 3'b010,
    ST_MARK = 3'b100
  } rcw_state_t;
endpackage

//--- core/rcw_sync.sv
// two-flop synchroniser for a pin input
// assumes the pin is asynchronous to mclk_i
`timescale 1ns/1ps
module rcw_sync (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  logic s2_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // rcw_sync

//--- core/rcw_decoder.sv
// configuration word decoder: data-line bit strobe in, two 12-bit registers out
// assumes an external bit clock pin marking each data bit, data stable at its rising edge
`timescale 1ns/1ps
module rcw_decoder (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        data_i,
  input  wire logic        bit_clk_i,
  input  wire logic        supply_loss_i,
  output logic             data_o,
  output logic             data_oe_n_o,
  output logic             polling_cmd_o,
  output logic [11:0]      operating_config_o,
  output logic [11:0]      edge_window_limits_o,
  output logic [1:0]       baud_range_sel_o,
  output logic [1:0]       bit_check_count_o,
  output logic             modulation_sel_o,
  output logic [4:0]       sleep_period_o,
  output logic             sleep_permanent_o,
  output logic             sleep_extension_o,
  output logic             noise_suppress_o,
  output logic [5:0]       lim_lower_o,
  output logic [5:0]       lim_upper_o
);
  // ==========================================
  // pin synchronisers
  logic data_s;
  logic bclk_s;
  logic loss_s;
  rcw_sync u_sync_data (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(data_i),        .q_o(data_s));
  rcw_sync u_sync_bclk (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(bit_clk_i),     .q_o(bclk_s));
  rcw_sync u_sync_loss (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(supply_loss_i), .q_o(loss_s));

  logic bclk_d_r;
  logic loss_d_r;
  logic bit_stb;
  logic loss_rise;
  assign bit_stb   = bclk_s & ~bclk_d_r;
  assign loss_rise = loss_s & ~loss_d_r;

  // ==========================================
  // decoder state
  rcw_pkg::rcw_state_t state_r;
  rcw_pkg::rcw_state_t state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        addr_r;
  logic        addr_nxt;
  logic [11:0] shift_r;
  logic [11:0] shift_nxt;
  logic [11:0] opcfg_r;
  logic [11:0] opcfg_nxt;
  logic [11:0] limits_r;
  logic [11:0] limits_nxt;
  logic        off_r;
  logic        off_nxt;
  logic        ignore_r;
  logic        ignore_nxt;
  logic [2:0]  mcnt_r;
  logic [2:0]  mcnt_nxt;
  logic        dout_r;
  logic        dout_nxt;
  logic        oe_n_r;
  logic        oe_n_nxt;
  logic        loss_pend_r;
  logic        loss_pend_nxt;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    addr_nxt   = addr_r;
    shift_nxt  = shift_r;
    opcfg_nxt  = opcfg_r;
    limits_nxt = limits_r;
    off_nxt    = 1'b0;
    ignore_nxt = ignore_r;
    mcnt_nxt   = mcnt_r;
    dout_nxt   = dout_r;
    oe_n_nxt   = oe_n_r;
    // a drop seen mid-word waits here, else the marker would be lost
    loss_pend_nxt = loss_pend_r | loss_rise;
    case (state_r)
      rcw_pkg::ST_CMD: begin
        if (loss_rise || loss_pend_r) begin
          // registers are suspect: restore defaults, then tell the host
          opcfg_nxt  = rcw_pkg::OPCFG_RST;
          limits_nxt = rcw_pkg::LIMITS_RST;
          mcnt_nxt   = 3'h0;
          oe_n_nxt   = 1'b0;
          loss_pend_nxt = 1'b0;
          dout_nxt   = rcw_pkg::MARKER_PAT[7];
          state_nxt  = rcw_pkg::ST_MARK;
        end else if (bit_stb) begin
          cnt_nxt    = 4'h1;
          ignore_nxt = data_s;
          off_nxt    = data_s;
          state_nxt  = rcw_pkg::ST_SHIFT;
        end
      end
      rcw_pkg::ST_SHIFT: begin
        if (bit_stb) begin
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == 4'h1) begin
            addr_nxt = data_s;
          end else if (cnt_r != rcw_pkg::BIT_CNT_LAST) begin
            shift_nxt = {shift_r[10:0], data_s};
          end else begin
            // stop bit: one discards the payload
            if (!ignore_r && !data_s) begin
              if (addr_r) begin
                opcfg_nxt  = shift_r;
              end else begin
                limits_nxt = shift_r;
              end
            end
            state_nxt = rcw_pkg::ST_CMD;
          end
        end
      end
      rcw_pkg::ST_MARK: begin
        if (bit_stb) begin
          if (mcnt_r == rcw_pkg::MARKER_LAST) begin
            oe_n_nxt  = 1'b1;
            dout_nxt  = 1'b1;
            state_nxt = rcw_pkg::ST_CMD;
          end else begin
            mcnt_nxt = mcnt_r + 3'h1;
            dout_nxt = rcw_pkg::MARKER_PAT[3'h6 - mcnt_r];
          end
        end
      end
      default: begin
        state_nxt = rcw_pkg::ST_CMD;
      end
    endcase
  end

  // registers are volatile: defaults return on reset or supply loss
  // edge history resets to the synchroniser's reset level, so no false edge follows reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bclk_d_r <= 1'b1;
      loss_d_r <= 1'b1;
      loss_pend_r <= 1'b0;
      state_r  <= rcw_pkg::ST_CMD;
      cnt_r    <= 4'h0;
      addr_r   <= 1'b0;
      shift_r  <= 12'h000;
      opcfg_r  <= rcw_pkg::OPCFG_RST;
      limits_r <= rcw_pkg::LIMITS_RST;
      off_r    <= 1'b0;
      ignore_r <= 1'b0;
      mcnt_r   <= 3'h0;
      dout_r   <= 1'b1;
      oe_n_r   <= 1'b1;
    end else begin
      bclk_d_r <= bclk_s;
      loss_d_r <= loss_s;
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      shift_r  <= shift_nxt;
      opcfg_r  <= opcfg_nxt;
      limits_r <= limits_nxt;
      off_r    <= off_nxt;
      ignore_r <= ignore_nxt;
      mcnt_r   <= mcnt_nxt;
      dout_r   <= dout_nxt;
      oe_n_r   <= oe_n_nxt;
      loss_pend_r <= loss_pend_nxt;
    end
  end

  // ==========================================
  // outputs
  assign data_o               = dout_r;
  assign data_oe_n_o          = oe_n_r;
  assign polling_cmd_o        = off_r;
  assign operating_config_o   = opcfg_r;
  assign edge_window_limits_o = limits_r;
  assign baud_range_sel_o     = {opcfg_r[rcw_pkg::OP_BAUD_HI], opcfg_r[rcw_pkg::OP_BAUD_LO]};
  assign bit_check_count_o    = {opcfg_r[rcw_pkg::OP_CHK_HI], opcfg_r[rcw_pkg::OP_CHK_LO]};
  assign modulation_sel_o     = opcfg_r[rcw_pkg::OP_MOD];
  assign sleep_period_o       = opcfg_r[rcw_pkg::OP_SLP_MSB:rcw_pkg::OP_SLP_LSB];
  assign sleep_permanent_o    = (sleep_period_o == rcw_pkg::SLEEP_PERM);
  assign sleep_extension_o    = opcfg_r[rcw_pkg::OP_SLP_EXT];
  assign noise_suppress_o     = opcfg_r[rcw_pkg::OP_NOISE];
  assign lim_lower_o          = limits_r[11:6];
  assign lim_upper_o          = limits_r[5:0];

  // ==========================================
  // checks
  a_off_no_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == rcw_pkg::ST_CMD && bit_stb && data_s && !loss_rise && !loss_pend_r)
      |=> polling_cmd_o ##1 ($stable(opcfg_r) && $stable(limits_r)))
    else $error("off command altered a register");
  a_stop_discard: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == rcw_pkg::ST_SHIFT && bit_stb && cnt_r == 4'hE && data_s)
      |=> ($stable(opcfg_r) && $stable(limits_r)))
    else $error("stop bit one still wrote");
  a_op_commit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == rcw_pkg::ST_SHIFT && bit_stb && cnt_r == 4'hE && !data_s && !ignore_r && addr_r)
      |=> (opcfg_r == $past(shift_r) && $stable(limits_r)))
    else $error("operating register not written");
  a_lim_commit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == rcw_pkg::ST_SHIFT && bit_stb && cnt_r == 4'hE && !data_s && !ignore_r && !addr_r)
      |=> (limits_r == $past(shift_r) && $stable(opcfg_r)))
    else $error("limits register not written");
  a_marker_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == rcw_pkg::ST_CMD && (loss_rise || loss_pend_r))
      |=> (!data_oe_n_o && data_o == rcw_pkg::MARKER_PAT[7] && opcfg_r == rcw_pkg::OPCFG_RST
           && limits_r == rcw_pkg::LIMITS_RST))
    else $error("marker not started after supply loss");
  a_idle_release: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r != rcw_pkg::ST_MARK) |-> data_oe_n_o)
    else $error("data driven outside marker");
  a_addr_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_r == rcw_pkg::ST_SHIFT && bit_stb && cnt_r == 4'h1) |=> (addr_r == $past(data_s)))
    else $error("address bit not captured");
  a_perm_sleep: assert property (@(posedge mclk_i) disable iff (rst_i)
    sleep_permanent_o == (opcfg_r[6:2] == 5'h1F))
    else $error("permanent sleep flag wrong");
endmodule // rcw_decoder

//--- test/rcw_host_model.sv
// host model: shifts configuration words in and clocks the marker out
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module rcw_host_model (
  input  wire logic mclk_i,
  input  wire logic line_i,
  output logic      drv_o,
  output logic      drv_en_o,
  output logic      bit_clk_o
);
  initial begin
    drv_o = 1'b1;
    drv_en_o = 1'b0;
    bit_clk_o = 1'b0;
  end
  // ==========================================
  // five cycles each side keeps data steady past the sync delay
  task automatic strobe();
    repeat (5) @(posedge mclk_i);
    #1 bit_clk_o = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1 bit_clk_o = 1'b0;
  endtask
  task automatic send_word(input logic [14:0] w);
    // an edge between words, so enable never toggles twice in one step
    @(posedge mclk_i);
    #1 drv_en_o = 1'b1;
    for (int i = 14; i >= 0; i--) begin
      drv_o = w[i];
      strobe();
    end
    repeat (5) @(posedge mclk_i);
    #1 drv_en_o = 1'b0;
  endtask
  task automatic read_marker(output logic [7:0] m);
    for (int i = 7; i >= 0; i--) begin
      m[i] = line_i;
      strobe();
    end
    repeat (5) @(posedge mclk_i);
    #1;
  endtask
endmodule // rcw_host_model

//--- test/rx_config_word_decoder_test.sv
// bench for the configuration word decoder
// assumes the host model and a pulled-up data wire
`timescale 1ns/1ps
module rx_config_word_decoder_test;
  logic        mclk_i = 1'b0, rst_i = 1'b1, supply_loss_i = 1'b0;
  logic        data_o, data_oe_n_o, polling_cmd_o, modulation_sel_o;
  logic        sleep_permanent_o, sleep_extension_o, noise_suppress_o;
  logic [11:0] operating_config_o, edge_window_limits_o;
  logic [1:0]  baud_range_sel_o, bit_check_count_o;
  logic [4:0]  sleep_period_o;
  logic [5:0]  lim_lower_o, lim_upper_o;
  logic        drv, drv_en, bit_clk, line;
  logic [7:0]  mark;
  logic [24:0] notes[$];
  logic [24:0] n;
  logic [11:0] exp_op = rcw_pkg::OPCFG_RST, exp_lim = rcw_pkg::LIMITS_RST;
  logic [11:0] prev_op = rcw_pkg::OPCFG_RST, prev_lim = rcw_pkg::LIMITS_RST;
  int          fail_count = 0, num_checks = 0;
  always #10 mclk_i = ~mclk_i;
  assign line = !data_oe_n_o ? data_o : (drv_en ? drv : 1'b1);
  rcw_decoder rcw_decoder_inst (.mclk_i(mclk_i), .rst_i(rst_i), .data_i(line), .bit_clk_i(bit_clk),
    .supply_loss_i(supply_loss_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o), .polling_cmd_o(polling_cmd_o),
    .operating_config_o(operating_config_o), .edge_window_limits_o(edge_window_limits_o),
    .baud_range_sel_o(baud_range_sel_o), .bit_check_count_o(bit_check_count_o),
    .modulation_sel_o(modulation_sel_o), .sleep_period_o(sleep_period_o), .sleep_permanent_o(sleep_permanent_o),
    .sleep_extension_o(sleep_extension_o), .noise_suppress_o(noise_suppress_o), .lim_lower_o(lim_lower_o),
    .lim_upper_o(lim_upper_o));
  rcw_host_model rcw_host_model_inst (.mclk_i(mclk_i), .line_i(line), .drv_o(drv), .drv_en_o(drv_en),
    .bit_clk_o(bit_clk));
  // ==========================================
  // checking
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a note is only made when something visible changes
  task automatic write_reg(input logic addr, input logic [11:0] p, input logic stop);
    logic [11:0] nop, nlim;
    nop = (!stop && addr) ? p : exp_op;
    nlim = (!stop && !addr) ? p : exp_lim;
    if ({nop, nlim} !== {exp_op, exp_lim}) notes.push_back({1'b0, nop, nlim});
    exp_op = nop;
    exp_lim = nlim;
    rcw_host_model_inst.send_word({1'b0, addr, p, stop});
  endtask
  always @(negedge mclk_i) begin
    if (!rst_i && (polling_cmd_o === 1'b1 || operating_config_o !== prev_op || edge_window_limits_o !== prev_lim)) begin
      n = notes.size() > 0 ? notes.pop_front() : 25'h1FFFFFF;
      check("polling", {11'h0, n[24]}, {11'h0, polling_cmd_o});
      check("operating", n[23:12], operating_config_o);
      check("limits", n[11:0], edge_window_limits_o);
      check("op fields", n[23:12], {baud_range_sel_o, bit_check_count_o, modulation_sel_o, sleep_period_o,
        sleep_extension_o, noise_suppress_o});
      check("lim fields", n[11:0], {lim_lower_o, lim_upper_o});
      check("perm sleep", {11'h0, n[18:14] == rcw_pkg::SLEEP_PERM}, {11'h0, sleep_permanent_o});
    end
    prev_op = operating_config_o;
    prev_lim = edge_window_limits_o;
  end
  initial begin
    repeat (30000) @(posedge mclk_i);
    fail_count++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(34));
    repeat (4) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    check("op reset", rcw_pkg::OPCFG_RST, operating_config_o);
    check("lim reset", rcw_pkg::LIMITS_RST, edge_window_limits_o);
    check("noise default", 12'h1, {11'h0, noise_suppress_o});
    $display("test reset done");
    for (int a = 0; a < 2; a++) begin
      write_reg(a[0], 12'($urandom), 1'b0);
      write_reg(a[0], 12'($urandom), 1'b1);
    end
    write_reg(1'b1, 12'h07C, 1'b0);
    write_reg(1'b0, 12'hFFF, 1'b0);
    $display("test writes done");
    notes.push_back({1'b1, exp_op, exp_lim});
    rcw_host_model_inst.send_word({1'b1, 14'($urandom)});
    write_reg(1'b1, 12'h000, 1'b0);
    $display("test off command done");
    exp_op = rcw_pkg::OPCFG_RST;
    exp_lim = rcw_pkg::LIMITS_RST;
    notes.push_back({1'b0, exp_op, exp_lim});
    supply_loss_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1;
    check("marker drive", 12'h0, {11'h0, data_oe_n_o});
    rcw_host_model_inst.read_marker(mark);
    check("marker", {4'h0, rcw_pkg::MARKER_PAT}, {4'h0, mark});
    check("marker end", 12'h1, {11'h0, data_oe_n_o});
    supply_loss_i = 1'b0;
    write_reg(1'b1, 12'($urandom), 1'b0);
    write_reg(1'b0, 12'($urandom), 1'b0);
    repeat (20) @(posedge mclk_i);
    check("notes left", 12'h0, 12'(notes.size()));
    $display("test supply loss done");
    finish_test();
  end
endmodule // rx_config_word_decoder_test
